// *** phy_ctrl_pkg.sv ***
// Purpose: Shared constants and carriers for the PHY port control block.
// Assumes: 200 MHz reference clock.
// Notes:   Register offsets follow the clause 22 numbering.
package phy_ctrl_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned BREAK_LINK_MS    = 1200;
    localparam int unsigned BREAK_LINK_CYC   = BREAK_LINK_MS * 1000 * CLK_MHZ;
    localparam int unsigned NIB100_DIV       = CLK_MHZ / 25;
    localparam int unsigned NIB10_DIV        = (CLK_MHZ * 10) / 25;
    localparam logic [4:0]  REG_CTRL         = 5'h00;
    localparam logic [4:0]  REG_STATUS       = 5'h01;
    localparam logic [4:0]  REG_ID1          = 5'h02;
    localparam logic [4:0]  REG_ID2          = 5'h03;
    localparam logic [4:0]  REG_ADV          = 5'h04;
    localparam logic [4:0]  REG_LPA          = 5'h05;
    localparam logic [4:0]  REG_EXP          = 5'h06;
    localparam logic [4:0]  REG_MODE         = 5'h11;
    localparam logic [4:0]  REG_SPECIAL      = 5'h1B;
    localparam logic [4:0]  REG_IRQ_SRC      = 5'h1D;
    localparam logic [4:0]  REG_IRQ_MASK     = 5'h1E;
    localparam logic [15:0] UNSUPPORTED_DATA = 16'hFFFF;
    localparam int unsigned CTRL_RESTART     = 9;
    localparam int unsigned CTRL_DUPLEX      = 8;
    localparam int unsigned CTRL_POWERDOWN   = 11;
    localparam int unsigned CTRL_AN_EN       = 12;
    localparam int unsigned CTRL_SPEED       = 13;
    localparam int unsigned EXP_LP_AN_ABLE   = 0;
    localparam int unsigned EXP_PD_FAULT     = 4;
    localparam int unsigned MODE_EDPD_EN     = 13;
    localparam int unsigned MODE_ENERGY      = 1;
    localparam int unsigned SPC_XOVER_OVR    = 15;
    localparam int unsigned SPC_XOVER_AUTO   = 14;
    localparam int unsigned SPC_XOVER_MAN    = 13;
    localparam int unsigned IRQ_ENERGY       = 7;
    localparam int unsigned IRQ_AN_DONE      = 6;
    localparam int unsigned IRQ_REMOTE_FAULT = 5;
    localparam int unsigned IRQ_LINK_DOWN    = 4;
    localparam int unsigned IRQ_LP_ACK       = 3;
    localparam int unsigned IRQ_PD_FAULT     = 2;
    localparam int unsigned IRQ_PAGE_RX      = 1;
    localparam int unsigned SYS_IRQ_PORT1    = 26;
    localparam int unsigned SYS_IRQ_PORT2    = 27;
    localparam logic [15:0] CTRL_RESET       = 16'h3100;
    localparam logic [15:0] ADV_RESET        = 16'h01E1;
    localparam logic [15:0] MODE_RESET       = 16'h0002;
    localparam logic [15:0] SPECIAL_RESET    = 16'h0000;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [15:0] ID1_VALUE        = 16'h1234;
    localparam logic [15:0] ID2_VALUE        = 16'h5678;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  data;
    } nibble_s;

    typedef struct packed {
        logic        flp_seen;
        logic        page_rx;
        logic [15:0] page_word;
        logic        ack_rx;
        logic        remote_fault;
        logic        mlt3_seen;
        logic        nlp_seen;
        logic        pd_fault;
        logic        signal_present;
    } line_evt_s;
endpackage

// *** phy_link_control_power_irq.sv ***
// Purpose: Control logic of one 10/100 PHY port: negotiation, duplex, crossover, MII, irq.
// Assumes: Line event inputs and straps come from outside the clock domain.
// Notes:   Management access is a one-cycle request with a registered read answer.
// Notes on behaviour
// - No bursts: speed from symbols, half duplex.
// - Parallel detect link clears partner-able flag.
// - Parallel detect fault sets expansion bit four.
// - Partner ability from page, or detected speed.
// - Host writes restart bit to renegotiate.
// - Signal loss restarts negotiation.
// - Software restart halts, waits break-link, renegotiates.
// - Negotiation off forces speed and duplex bits.
// - Forced bits ignored while negotiation on.
// - Half duplex: carrier both ways, collision.
// - Full duplex: carrier from receive, no collision.
// - Override clear: straps select crossover.
// - Override set: register bits select crossover.
// - Nibbles at 25 or 2.5 MHz.
// - Receive clock recovered, else from reference.
// - Unsupported register reads return all ones.
// - Source read returns flags, clears indication.
// - Masked sources merge into port interrupt.
// - Source bits placed seven down to one.
// - General power-down keeps registers, resets PHY.
// - Energy power-down: no energy, no transmit.
// - Energy return powers up, sets flag seven.
// - Resolve abilities in fixed priority order.
// - Advertisement write waits for restart.
`timescale 1ns/1ps
module phy_link_control_power_irq #(
    parameter int unsigned BREAK_CYCLES = phy_ctrl_pkg::BREAK_LINK_CYC,
    parameter bit          PORT_TWO     = 1'b0
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire phy_ctrl_pkg::mgmt_req_s mgmt,
    output logic [15:0]                  mgmt_rdata,
    output logic                         mgmt_rvalid,
    input  wire phy_ctrl_pkg::line_evt_s line_in,
    input  wire logic                    energy_in,
    input  wire logic                    auto_xover_strap,
    input  wire logic                    manual_xover_strap,
    input  wire phy_ctrl_pkg::nibble_s   tx_in,
    output logic                         tx_ready,
    output phy_ctrl_pkg::nibble_s        line_tx,
    input  wire phy_ctrl_pkg::nibble_s   line_rx,
    output phy_ctrl_pkg::nibble_s        rx_out,
    input  wire logic                    rx_ready,
    output logic                         rx_clk,
    output logic                         crs,
    output logic                         col,
    output logic                         speed_100,
    output logic                         full_duplex,
    output logic                         link_up,
    output logic                         xover_auto,
    output logic                         xover_swap,
    output logic                         phy_powered,
    output logic                         phy_irq,
    output logic [31:0]                  system_irq_status
);
    import phy_ctrl_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_BREAK = 5'b00010,
        ST_NEG   = 5'b00100,
        ST_LINK  = 5'b01000,
        ST_FORCE = 5'b10000
    } an_state_e;

    function automatic logic [1:0] resolve(input logic [3:0] common);
        if (common[3]) resolve = 2'b11;
        else if (common[2]) resolve = 2'b10;
        else if (common[1]) resolve = 2'b01;
        else resolve = 2'b00;
    endfunction

    // Synchronisers for the line events, the energy input and the straps; line_rx is not synchronised.
    localparam int unsigned SW = $bits(line_evt_s) + 3;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {line_in, energy_in, auto_xover_strap, manual_xover_strap};
            sync_b <= sync_a;
        end
    end
    line_evt_s ev;
    logic      energy_s;
    logic      auto_strap_s;
    logic      man_strap_s;
    assign {ev, energy_s, auto_strap_s, man_strap_s} = sync_b;

    logic [15:0] ctrl_reg;
    logic [15:0] advertisement_reg;
    logic [15:0] partner_ability_reg;
    logic [15:0] autoneg_expansion_reg;
    logic [15:0] mode_ctrl_status_reg;
    logic [15:0] special_ctrl_status_reg;
    logic [7:0]  irq_source_reg;
    logic [7:0]  irq_mask_reg;
    logic [3:0]  adv_latched;
    logic        wr_ctrl;
    logic        rd_src;
    logic        restart_req;
    assign wr_ctrl = mgmt.req && mgmt.write && mgmt.addr == REG_CTRL;
    assign rd_src  = mgmt.req && !mgmt.write && mgmt.addr == REG_IRQ_SRC;
    assign restart_req = wr_ctrl && mgmt.wdata[CTRL_RESTART];

    logic energy_present;
    logic edpd_down;
    logic pd_prev;
    logic wake_pulse;
    assign energy_present = energy_s;
    assign edpd_down = mode_ctrl_status_reg[MODE_EDPD_EN] && !energy_present;
    assign phy_powered = !ctrl_reg[CTRL_POWERDOWN] && !edpd_down;

    // Leaving any power-down restarts the port, registers keep their values.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) pd_prev <= 1'b0;
        else pd_prev <= !phy_powered;
    end
    assign wake_pulse = pd_prev && phy_powered;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            advertisement_reg <= ADV_RESET;
            mode_ctrl_status_reg <= MODE_RESET;
            special_ctrl_status_reg <= SPECIAL_RESET;
            irq_mask_reg <= MASK_RESET;
        end else begin
            mode_ctrl_status_reg[MODE_ENERGY] <= energy_present;
            if (mgmt.req && mgmt.write) begin
                case (mgmt.addr)
                    REG_CTRL: ctrl_reg <= mgmt.wdata & 16'hFDFF;
                    REG_ADV: advertisement_reg <= mgmt.wdata;
                    REG_MODE: mode_ctrl_status_reg[MODE_EDPD_EN] <= mgmt.wdata[MODE_EDPD_EN];
                    REG_SPECIAL: special_ctrl_status_reg <= mgmt.wdata;
                    REG_IRQ_MASK: irq_mask_reg <= mgmt.wdata[7:0] & 8'hFE;
                    default: ;
                endcase
            end
        end
    end

    an_state_e   state;
    logic [31:0] break_cnt;
    logic        sig_prev;
    logic        link_lost;
    logic        neg_speed;
    logic        neg_duplex;
    logic [1:0]  hcd;
    logic [3:0]  common;
    assign link_lost = sig_prev && !ev.signal_present;
    assign common = adv_latched & partner_ability_reg[8:5];
    assign hcd = resolve(common);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) sig_prev <= 1'b0;
        else sig_prev <= ev.signal_present;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_NEG;
            break_cnt <= '0;
            adv_latched <= ADV_RESET[8:5];
            neg_speed <= 1'b0;
            neg_duplex <= 1'b0;
        end else if (!phy_powered) begin
            state <= ST_IDLE;
        end else if (restart_req) begin
            state <= ST_BREAK;
            break_cnt <= '0;
        end else if (wake_pulse || (link_lost && ctrl_reg[CTRL_AN_EN])) begin
            state <= ST_NEG;
            adv_latched <= advertisement_reg[8:5];
        end else if (!ctrl_reg[CTRL_AN_EN]) begin
            state <= ST_FORCE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_NEG;
                ST_FORCE: state <= ST_NEG;
                ST_BREAK: begin
                    if (break_cnt >= BREAK_CYCLES - 1) begin
                        state <= ST_NEG;
                        adv_latched <= advertisement_reg[8:5];
                    end else begin
                        break_cnt <= break_cnt + 32'd1;
                    end
                end
                ST_NEG: begin
                    if (ev.flp_seen && ev.ack_rx && common != 4'h0) begin
                        state <= ST_LINK;
                        neg_speed <= hcd[1];
                        neg_duplex <= hcd[0];
                    end else if (!ev.flp_seen && (ev.mlt3_seen || ev.nlp_seen)
                                 && !ev.pd_fault) begin
                        state <= ST_LINK;
                        neg_speed <= ev.mlt3_seen;
                        neg_duplex <= 1'b0;
                    end
                end
                ST_LINK: ;
                default: state <= ST_NEG;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            partner_ability_reg <= '0;
            autoneg_expansion_reg <= '0;
        end else if (state == ST_NEG && phy_powered) begin
            if (ev.page_rx) begin
                partner_ability_reg <= ev.page_word;
                autoneg_expansion_reg[EXP_LP_AN_ABLE] <= 1'b1;
            end else if (!ev.flp_seen && (ev.mlt3_seen || ev.nlp_seen) && !ev.pd_fault) begin
                partner_ability_reg <= {8'h00, ev.mlt3_seen, 1'b0, !ev.mlt3_seen, 5'h01};
                autoneg_expansion_reg[EXP_LP_AN_ABLE] <= 1'b0;
            end
            if (ev.pd_fault) autoneg_expansion_reg[EXP_PD_FAULT] <= 1'b1;
        end else if (mgmt.req && !mgmt.write && mgmt.addr == REG_EXP) begin
            autoneg_expansion_reg[EXP_PD_FAULT] <= 1'b0;
        end
    end
    assign link_up = state == ST_LINK || (state == ST_FORCE && ev.signal_present);
    assign speed_100 = state == ST_FORCE ? ctrl_reg[CTRL_SPEED] : neg_speed;
    assign full_duplex = state == ST_FORCE ? ctrl_reg[CTRL_DUPLEX] : neg_duplex;
    // Interrupt sources: a new event in the read cycle survives the clear.
    logic [7:0] irq_events;
    logic       down_evt;
    logic       link_prev;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) link_prev <= 1'b0;
        else link_prev <= link_up;
    end
    assign down_evt = link_prev && !link_up;
    always_comb begin
        irq_events = 8'h00;
        irq_events[IRQ_ENERGY] = wake_pulse && mode_ctrl_status_reg[MODE_EDPD_EN];
        irq_events[IRQ_AN_DONE] = state == ST_NEG && !link_prev && link_up == 1'b0
                                  && ev.flp_seen && ev.ack_rx && common != 4'h0;
        irq_events[IRQ_REMOTE_FAULT] = ev.remote_fault;
        irq_events[IRQ_LINK_DOWN] = down_evt;
        irq_events[IRQ_LP_ACK] = ev.ack_rx && state == ST_NEG;
        irq_events[IRQ_PD_FAULT] = ev.pd_fault && state == ST_NEG;
        irq_events[IRQ_PAGE_RX] = ev.page_rx && state == ST_NEG;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) irq_source_reg <= 8'h00;
        else if (rd_src) irq_source_reg <= irq_events;
        else irq_source_reg <= irq_source_reg | irq_events;
    end
    assign phy_irq = |(irq_source_reg & irq_mask_reg);
    always_comb begin
        system_irq_status = 32'h0000_0000;
        system_irq_status[PORT_TWO ? SYS_IRQ_PORT2 : SYS_IRQ_PORT1] = phy_irq;
    end

    // Management read answer, registered one cycle after the request.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt.req && !mgmt.write;
            if (mgmt.req && !mgmt.write) begin
                case (mgmt.addr)
                    REG_CTRL: mgmt_rdata <= ctrl_reg;
                    REG_STATUS: mgmt_rdata <= {9'h0F8, 1'b0, state == ST_LINK, 2'b00,
                                               link_up, 2'b01};
                    REG_ID1: mgmt_rdata <= ID1_VALUE;
                    REG_ID2: mgmt_rdata <= ID2_VALUE;
                    REG_ADV: mgmt_rdata <= advertisement_reg;
                    REG_LPA: mgmt_rdata <= partner_ability_reg;
                    REG_EXP: mgmt_rdata <= autoneg_expansion_reg;
                    REG_MODE: mgmt_rdata <= mode_ctrl_status_reg;
                    REG_SPECIAL: mgmt_rdata <= special_ctrl_status_reg;
                    REG_IRQ_SRC: mgmt_rdata <= {8'h00, irq_source_reg};
                    REG_IRQ_MASK: mgmt_rdata <= {8'h00, irq_mask_reg};
                    default: mgmt_rdata <= UNSUPPORTED_DATA;
                endcase
            end
        end
    end

    // Crossover selection.
    always_comb begin
        if (special_ctrl_status_reg[SPC_XOVER_OVR]) begin
            xover_auto = special_ctrl_status_reg[SPC_XOVER_AUTO];
            xover_swap = special_ctrl_status_reg[SPC_XOVER_MAN];
        end else begin
            xover_auto = auto_strap_s;
            xover_swap = !auto_strap_s && man_strap_s;
        end
    end

    // Nibble strobe: 25 MHz or 2.5 MHz enable pulse from the reference clock.
    logic [7:0] nib_cnt;
    logic       nib_en;
    logic [7:0] nib_div;
    assign nib_div = speed_100 ? 8'(NIB100_DIV) : 8'(NIB10_DIV);
    assign nib_en = nib_cnt == 8'h00;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) nib_cnt <= 8'h00;
        else if (nib_en) nib_cnt <= nib_div - 8'd1;
        else nib_cnt <= nib_cnt - 8'd1;
    end
    // Receive clock falls back to the divided reference clock without line signal.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) rx_clk <= 1'b0;
        else if (line_rx.valid && link_up) rx_clk <= !rx_clk;
        else if (nib_en || nib_cnt == (nib_div >> 1)) rx_clk <= !rx_clk;
    end
    logic data_ok;
    assign data_ok = phy_powered && link_up && state != ST_BREAK;

    // Transmit: nibbles leave one per strobe; the MAC stalls on tx_ready.
    // Ready stays low while the path is closed, so the MAC never loses a nibble.
    assign tx_ready = data_ok && !restart_req && (!line_tx.valid || nib_en);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) line_tx <= '0;
        else if (!data_ok || restart_req) line_tx <= '0;
        else if (tx_ready) line_tx <= tx_in;
    end

    // Two-entry receive buffer for a stalled MAC; a nibble arriving while both entries are full is dropped.
    nibble_s    rxb [2];
    logic [1:0] rx_count;
    logic       rx_wr;
    logic       rx_rd;
    logic       rx_sel;
    assign rx_wr = line_rx.valid && data_ok && rx_count != 2'd2;
    assign rx_rd = rx_count != 2'd0 && rx_ready;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxb[0] <= '0;
            rxb[1] <= '0;
            rx_count <= 2'd0;
            rx_sel <= 1'b0;
        end else begin
            if (rx_wr) rxb[rx_sel ^ rx_count[0]] <= line_rx;
            if (rx_rd) rx_sel <= !rx_sel;
            rx_count <= rx_count + {1'b0, rx_wr} - {1'b0, rx_rd};
        end
    end
    always_comb begin
        rx_out = rxb[rx_sel];
        rx_out.valid = rx_count != 2'd0;
    end

    assign crs = full_duplex ? line_rx.valid && data_ok
                             : (line_rx.valid || line_tx.valid) && data_ok;
    assign col = !full_duplex && line_rx.valid && line_tx.valid && data_ok;
    property p_unsup;
        @(posedge ref_clk) disable iff (rst)
        mgmt.req && !mgmt.write && mgmt.addr == 5'h07 |=> mgmt_rdata == 16'hFFFF;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported read not FFFF");
    property p_full_nocol;
        @(posedge ref_clk) disable iff (rst) full_duplex |-> !col;
    endproperty
    a_full_nocol: assert property (p_full_nocol) else $error("collision in full duplex");
    property p_half_crs;
        @(posedge ref_clk) disable iff (rst)
        !full_duplex && data_ok && line_tx.valid |-> crs;
    endproperty
    a_half_crs: assert property (p_half_crs) else $error("no carrier on transmit");
    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        restart_req && phy_powered |=> state == ST_BREAK && !line_tx.valid;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not break link");
    property p_edpd;
        @(posedge ref_clk) disable iff (rst) edpd_down |=> !line_tx.valid;
    endproperty
    a_edpd: assert property (p_edpd) else $error("transmit while energy down");
    property p_irq_hold;
        @(posedge ref_clk) disable iff (rst)
        phy_irq && !rd_src && !(mgmt.req && mgmt.write && mgmt.addr == REG_IRQ_MASK) |=> phy_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
    property p_xover;
        @(posedge ref_clk) disable iff (rst)
        special_ctrl_status_reg[SPC_XOVER_OVR] |-> xover_auto == special_ctrl_status_reg[14];
    endproperty
    a_xover: assert property (p_xover) else $error("override ignored");
    property p_rxbuf;
        @(posedge ref_clk) disable iff (rst) rx_count <= 2'd2;
    endproperty
    a_rxbuf: assert property (p_rxbuf) else $error("receive buffer overflow");
endmodule

// *** mac_model.sv ***
// Purpose: Behavioural switch-side MAC on the internal nibble interface.
// Assumes: Same clock as the port; stall_en asks for receive back-pressure.
// Notes:   A nibble is held until the port takes it, so none is skipped.
`timescale 1ns/1ps
module mac_model (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  stall_en,
    input  wire logic                  tx_ready,
    input  wire phy_ctrl_pkg::nibble_s rx_out,
    output phy_ctrl_pkg::nibble_s      tx_in,
    output logic                       rx_ready
);
    import phy_ctrl_pkg::*;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_in <= '0;
        end else if (!tx_in.valid || tx_ready) begin
            tx_in.valid <= 1'b1;
            tx_in.data  <= tx_in.data + 4'h1;
        end
    end
    // Stalling on every other cycle exercises the two-entry receive buffer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= !stall_en || !rx_ready;
        end
    end
endmodule

// *** phy_link_control_power_irq_test.sv ***
// Purpose: Self-checking bench for the PHY port control block.
// Assumes: Synchronised inputs settle within six clock cycles.
// Notes:   Read answers are checked from a queue of expected words.
`timescale 1ns/1ps
module phy_link_control_power_irq_test;
    import phy_ctrl_pkg::*;
    logic ref_clk, rst, energy_in, auto_s, man_s, stall, tx_ready, rx_ready, rx_clk;
    logic crs, col, speed_100, full_duplex, link_up, xover_auto, xover_swap;
    logic phy_powered, phy_irq, mgmt_rvalid;
    logic [15:0] mgmt_rdata;
    logic [31:0] system_irq_status, r, e;
    mgmt_req_s mgmt;
    line_evt_s line_in;
    nibble_s tx_in, line_tx, line_rx, rx_out;
    logic [31:0] exp_q[$];
    int failures, check_count, seed;
    phy_link_control_power_irq #(.BREAK_CYCLES(20)) dut (.ref_clk(ref_clk), .rst(rst),
        .mgmt(mgmt), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .line_in(line_in),
        .energy_in(energy_in), .auto_xover_strap(auto_s), .manual_xover_strap(man_s),
        .tx_in(tx_in), .tx_ready(tx_ready), .line_tx(line_tx), .line_rx(line_rx),
        .rx_out(rx_out), .rx_ready(rx_ready), .rx_clk(rx_clk), .crs(crs), .col(col),
        .speed_100(speed_100), .full_duplex(full_duplex), .link_up(link_up),
        .xover_auto(xover_auto), .xover_swap(xover_swap), .phy_powered(phy_powered),
        .phy_irq(phy_irq), .system_irq_status(system_irq_status));
    mac_model mac (.ref_clk(ref_clk), .rst(rst), .stall_en(stall), .tx_ready(tx_ready),
        .rx_out(rx_out), .tx_in(tx_in), .rx_ready(rx_ready));
    always #2.5 ref_clk = ~ref_clk;
    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A read notes its expected word and the bits that matter.
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d,
                       input logic [15:0] m);
        @(posedge ref_clk);
        mgmt <= '{req: 1'b1, write: wr, addr: a, wdata: d};
        if (!wr) exp_q.push_back({d, m});
        @(posedge ref_clk);
        mgmt.req <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (mgmt_rvalid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_word(mgmt_rdata & e[15:0], e[31:16]);
        end
    end
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        ref_clk = 0; rst = 1; seed = 33; mgmt = '0; line_in = '0; line_rx = '0;
        energy_in = 1; auto_s = 0; man_s = 0; stall = 1;
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        settle();
        acc(0, 5'h07, 16'hFFFF, 16'hFFFF);
        acc(0, 5'h1F, 16'hFFFF, 16'hFFFF);
        acc(1, REG_CTRL, 16'h2300, 16'h0000);
        acc(0, REG_CTRL, 16'h2100, 16'hFFFF);
        cmp_out(speed_100 & full_duplex, 32'h1);
        acc(1, REG_CTRL, 16'h0800, 16'h0000);
        cmp_out(phy_powered, 32'h0);
        cmp_out(speed_100 | full_duplex, 32'h0);
        acc(1, REG_CTRL, 16'h0100, 16'h0000);
        acc(0, REG_CTRL, 16'h0100, 16'hFFFF);
        cmp_out(phy_powered, 32'h1);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            auto_s <= r[0];
            man_s <= r[1];
            settle();
            cmp_out(xover_auto, r[0]);
            if (!r[0]) cmp_out(xover_swap, r[1]);
        end
        for (int i = 0; i < 4; i++) begin
            acc(1, REG_SPECIAL, {1'b1, i[1:0], 13'h0000}, 16'h0000);
            cmp_out(xover_auto, i[1]);
            if (!i[1]) cmp_out(xover_swap, i[0]);
        end
        // Forced 10M link: one nibble per strobe, carrier and collision follow duplex.
        line_in.signal_present <= 1'b1;
        line_rx <= '{valid: 1'b1, data: 4'hA};
        settle();
        cmp_out({link_up, speed_100, full_duplex}, 32'h5);
        cmp_out({crs, col, rx_out}, 32'h5A);
        r = {27'h0, line_tx};
        repeat (NIB10_DIV) @(posedge ref_clk);
        cmp_out(line_tx, {1'b1, r[3:0] + 4'h1});
        acc(1, REG_CTRL, 16'h0000, 16'h0000);
        cmp_out({crs, col}, 32'h3);
        line_rx <= '0;
        line_in.signal_present <= 1'b0;
        @(posedge ref_clk);
        cmp_out({crs, col}, 32'h2);
        acc(0, REG_IRQ_SRC, 16'h0000, 16'h0000);
        acc(1, REG_IRQ_MASK, 16'h0020, 16'h0000);
        acc(1, REG_CTRL, 16'h1000, 16'h0000);
        line_in.pd_fault <= 1'b1;
        settle();
        cmp_out(phy_irq, 32'h0);
        line_in.remote_fault <= 1'b1;
        settle();
        cmp_out(system_irq_status, 32'h0400_0000);
        line_in.pd_fault <= 1'b0;
        line_in.remote_fault <= 1'b0;
        settle();
        acc(0, REG_EXP, 16'h0010, 16'h0010);
        acc(0, REG_IRQ_SRC, 16'h0024, 16'h0024);
        cmp_out(phy_irq, 32'h0);
        line_in.signal_present <= 1'b1;
        line_in.mlt3_seen <= 1'b1;
        settle();
        cmp_out({link_up, speed_100, full_duplex}, 32'h6);
        acc(0, REG_LPA, 16'h0081, 16'hFFFF);
        acc(0, REG_EXP, 16'h0000, 16'h0001);
        line_in.signal_present <= 1'b0;
        line_in.mlt3_seen <= 1'b0;
        settle();
        cmp_out(link_up, 32'h0);
        // The mask now names only the energy wake source.
        acc(1, REG_IRQ_MASK, 16'h0080, 16'h0000);
        acc(1, REG_MODE, 16'h2000, 16'h0000);
        energy_in <= 1'b0;
        settle();
        cmp_out(phy_powered, 32'h0);
        acc(0, REG_MODE, 16'h2000, 16'h2002);
        stall <= 1'b0;
        energy_in <= 1'b1;
        settle();
        cmp_out({phy_powered, phy_irq}, 32'h3);
        acc(0, REG_MODE, 16'h2002, 16'h2002);
        acc(0, REG_IRQ_SRC, 16'h0080, 16'h0080);
        settle();
        print_verdict();
    end
endmodule
